// ### core/dic_input_conditioning.sv
// Digital input conditioning: forcing, inversion, special functions, routing
//
// Notes on behaviour
// - Physical inputs are sampled once per millisecond; shorter pulses may vanish.
// - Function enable bits: 0 negative limit, 1 positive limit, 2 home, 3 interlock.
// - Function enable word never touches level bits 16 to 31.
// - Every configuration word except routing enable acts per bit; bit n-1 belongs to input n.
// - Invert bit 0 reports high as 1, bit 1 reports high as 0.
// - Force enable bit set replaces the sampled level with a software value.
// - The forced value comes from the matching bit of the force value word.
// - Raw word returns sampled levels before forcing, inversion and routing.
// - Range bit selects threshold: 0 is 5 V, 1 is 24 V.
// - Input 1: bit 0 is negative limit result, bit 16 its level.
// - Writing 1 to routing enable subindex 08 turns routing on.
// - While routing, invert, force enable and force value are ignored; enable still gates the interlock.
// - Turning routing on loads defaults that keep the inputs behaving unchanged.
// - Table entry k selects the source of status bit k-1.
// - Codes: 00 zero, 01-10 inputs, 41-43 Hall, 44-46 encoder.
// - Code bit 7 inverts; 80 gives one, 81 to C6 inverted sources.
// - Status bit 3 high permits motion; low raises the interlock fault.
// - Interlock acts only with function enable bit 3 set.
// - Functions sit in bits 0 to 15, input n level at 15+n.
`timescale 1ns/100ps
`default_nettype none
module dic_input_conditioning #(
    parameter int NUM_IN = 4,
    parameter int SAMPLE_CYCLES = dic_pkg::SAMPLE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [NUM_IN-1:0] pinIn,
    input wire logic [2:0] hallIn,
    input wire logic [2:0] encIn,
    input wire dic_pkg::dic_obj_req_t objReq,
    output dic_pkg::dic_obj_rsp_t objRsp,
    output logic [31:0] statusWord,
    output logic [NUM_IN-1:0] thresholdSel,
    output logic motionPermit,
    output logic interlockFault
);
    localparam int SW = NUM_IN + 6;

    dic_pkg::dic_state_t st;
    dic_pkg::dic_state_t nx;
    logic [SW-1:0] sampled;
    logic sampleTick;
    logic [NUM_IN-1:0] normLevel;
    logic [31:0] normStatus;
    logic [31:0] routeStatus;
    logic [31:0][7:0] defTab;
    logic [dic_pkg::MAX_INPUTS-1:0] physPad;
    logic [2:0] hallS;
    logic [2:0] encS;
    logic [31:0] rawWord;

    // Hall and encoder lines go through the same sampler so all sources share one timebase
    dic_sampler #(
        .WIDTH(SW),
        .PERIOD(SAMPLE_CYCLES)
    ) u_sampler (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .asyncIn({encIn, hallIn, pinIn}),
        .sampled(sampled),
        .tick(sampleTick)
    );

    assign hallS = sampled[NUM_IN +: 3];
    assign encS = sampled[NUM_IN + 3 +: 3];
    assign physPad = dic_pkg::MAX_INPUTS'(sampled[NUM_IN-1:0]);
    assign rawWord = 32'(sampled[NUM_IN-1:0]);

    function automatic logic srcValue(
        input logic [7:0] code,
        input logic [dic_pkg::MAX_INPUTS-1:0] phys,
        input logic [2:0] hall,
        input logic [2:0] enc
    );
        logic [6:0] sel;
        logic v;
        sel = code[6:0];
        v = 1'b0;
        if (sel >= dic_pkg::SRC_PHYS_FIRST && sel <= dic_pkg::SRC_PHYS_LAST) begin
            v = phys[4'(sel - dic_pkg::SRC_PHYS_FIRST)];
        end else if (sel >= dic_pkg::SRC_HALL_U && sel <= dic_pkg::SRC_HALL_W) begin
            v = hall[2'(sel - dic_pkg::SRC_HALL_U)];
        end else if (sel >= dic_pkg::SRC_ENC_A && sel <= dic_pkg::SRC_ENC_IDX) begin
            v = enc[2'(sel - dic_pkg::SRC_ENC_A)];
        end
        return v ^ code[dic_pkg::SRC_INV_BIT];
    endfunction

    // Normal-mode level per input
    for (genvar i = 0; i < NUM_IN; i++) begin : g_in
        logic picked;
        assign picked = st.forceEn[i] ? st.forceVal[i] : sampled[i];
        assign normLevel[i] = picked ^ st.invert[i];
    end

    always_comb begin
        normStatus = '0;
        normStatus[NUM_IN-1:0] = normLevel & st.fnEnable[NUM_IN-1:0];
        normStatus[dic_pkg::LEVEL_BASE +: NUM_IN] = normLevel;
    end

    // Routed status bits and the defaults that mimic normal mode
    for (genvar k = 0; k < 32; k++) begin : g_map
        localparam int N = (k >= dic_pkg::LEVEL_BASE) ? k - dic_pkg::LEVEL_BASE : k;
        assign routeStatus[k] = srcValue(st.routeTab[k], physPad, hallS, encS);
        if (N < NUM_IN) begin : g_def
            logic used;
            assign used = (k >= dic_pkg::LEVEL_BASE) ? 1'b1 : st.fnEnable[k];
            // Forced inputs become constants so the switch-over is seamless
            assign defTab[k] = !used ? 8'h00 :
                st.forceEn[N] ? {st.forceVal[N] ^ st.invert[N], dic_pkg::SRC_CONST} :
                {st.invert[N], 7'(N + 1)};
        end else begin : g_none
            assign defTab[k] = 8'h00;
        end
    end

    always_comb begin
        logic [31:0] rdVal;
        logic hit;
        logic ro;
        logic wr;
        logic [4:0] entry;
        rdVal = '0;
        hit = 1'b1;
        ro = 1'b0;
        wr = objReq.valid && objReq.write;
        entry = 5'(objReq.sub - 8'h01);
        nx = st;
        if (objReq.index == dic_pkg::IDX_CFG) begin
            case (objReq.sub)
                dic_pkg::SUB_COUNT: begin
                    rdVal = 32'(dic_pkg::SUB_ROUTE_EN);
                    ro = 1'b1;
                end
                dic_pkg::SUB_FN_ENABLE: begin
                    rdVal = st.fnEnable;
                    if (wr) nx.fnEnable = objReq.wdata;
                end
                dic_pkg::SUB_INVERT: begin
                    rdVal = st.invert;
                    if (wr) nx.invert = objReq.wdata;
                end
                dic_pkg::SUB_FORCE_EN: begin
                    rdVal = st.forceEn;
                    if (wr) nx.forceEn = objReq.wdata;
                end
                dic_pkg::SUB_FORCE_VAL: begin
                    rdVal = st.forceVal;
                    if (wr) nx.forceVal = objReq.wdata;
                end
                dic_pkg::SUB_RAW: begin
                    rdVal = rawWord;
                    ro = 1'b1;
                end
                dic_pkg::SUB_RANGE: begin
                    rdVal = st.rangeSel;
                    if (wr) nx.rangeSel = objReq.wdata;
                end
                dic_pkg::SUB_ROUTE_EN: begin
                    rdVal = {31'h0, st.routeEn};
                    if (wr) begin
                        nx.routeEn = objReq.wdata[0];
                        // Only the off-to-on edge reloads; rewriting 1 keeps the user table
                        if (objReq.wdata[0] && !st.routeEn) nx.routeTab = defTab;
                    end
                end
                default: hit = 1'b0;
            endcase
        end else if (objReq.index == dic_pkg::IDX_MAP) begin
            if (objReq.sub == dic_pkg::SUB_COUNT) begin
                rdVal = 32'(dic_pkg::MAP_ENTRIES);
                ro = 1'b1;
            end else if (objReq.sub <= dic_pkg::MAP_ENTRIES) begin
                rdVal = 32'(st.routeTab[entry]);
                if (wr) nx.routeTab[entry] = objReq.wdata[7:0];
            end else begin
                hit = 1'b0;
            end
        end else if (objReq.index == dic_pkg::IDX_STATUS && objReq.sub == dic_pkg::SUB_COUNT) begin
            rdVal = st.status;
            ro = 1'b1;
        end else begin
            hit = 1'b0;
        end
        if (!hit || ro) begin
            nx.fnEnable = st.fnEnable;
        end
        nx.rsp.ack = objReq.valid;
        nx.rsp.err = objReq.valid && (!hit || (objReq.write && ro));
        nx.rsp.rdata = (objReq.valid && !objReq.write && hit) ? rdVal : '0;

        nx.status = st.routeEn ? routeStatus : normStatus;
        nx.permit = !st.fnEnable[dic_pkg::FN_INTERLOCK] || st.status[dic_pkg::FN_INTERLOCK];
        nx.fault = st.permit && !nx.permit;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st <= dic_pkg::STATE_RESET;
        end else begin
            st <= nx;
        end
    end

    assign objRsp = st.rsp;
    assign statusWord = st.status;
    assign thresholdSel = st.rangeSel[NUM_IN-1:0];
    assign motionPermit = st.permit;
    assign interlockFault = st.fault;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    AST_LEVEL_BITS: assert property (!st.routeEn |=>
        statusWord[dic_pkg::LEVEL_BASE +: NUM_IN] == $past(normLevel))
        else $error("level bits differ from computed levels");
    AST_FUNC_BITS: assert property (!st.routeEn |=>
        statusWord[NUM_IN-1:0] == ($past(normLevel) & $past(st.fnEnable[NUM_IN-1:0])))
        else $error("function bits not level and enable");
    AST_FORCE_INPUT1: assert property ((!st.routeEn && st.forceEn[0] && !st.invert[0]) |=>
        statusWord[dic_pkg::LEVEL_BASE] == $past(st.forceVal[0]))
        else $error("forced value not reported");
    AST_INVERT_INPUT1: assert property ((!st.routeEn && !st.forceEn[0] && st.invert[0]) |=>
        statusWord[dic_pkg::LEVEL_BASE] == !$past(sampled[0]))
        else $error("inverted input reported wrong level");
    AST_RAW_READ: assert property ((objReq.valid && !objReq.write && objReq.index == dic_pkg::IDX_CFG &&
        objReq.sub == dic_pkg::SUB_RAW) |=> objRsp.ack && objRsp.rdata == $past(rawWord))
        else $error("raw read does not return sampled levels");
    AST_ROUTE_ON: assert property ((objReq.valid && objReq.write && objReq.index == dic_pkg::IDX_CFG &&
        objReq.sub == dic_pkg::SUB_ROUTE_EN && objReq.wdata[0]) |=> st.routeEn)
        else $error("routing not enabled by write of one");
    AST_ROUTE_SEAMLESS: assert property (($rose(st.routeEn) && $stable(sampled)) |=>
        $stable(statusWord))
        else $error("status changed when routing was enabled");
    AST_ROUTE_CONST_ONE: assert property ((st.routeEn && st.routeTab[0] == 8'h80) |=>
        statusWord[0])
        else $error("code 80 did not give one");
    AST_ROUTE_IGNORES_CFG: assert property ((st.routeEn && st.routeTab[16] == 8'h00) |=>
        !statusWord[dic_pkg::LEVEL_BASE])
        else $error("routed constant zero overridden");
    AST_INTERLOCK_DROP: assert property ((st.fnEnable[dic_pkg::FN_INTERLOCK] &&
        !statusWord[dic_pkg::FN_INTERLOCK]) |=> !motionPermit)
        else $error("motion permitted with interlock low");
    AST_INTERLOCK_OFF: assert property (!st.fnEnable[dic_pkg::FN_INTERLOCK] |=> motionPermit)
        else $error("interlock acted while disabled");
    AST_FAULT_PULSE: assert property (interlockFault |-> $past(motionPermit) && !motionPermit)
        else $error("fault pulse without permit drop");
    AST_RANGE: assert property ((objReq.valid && objReq.write && objReq.index == dic_pkg::IDX_CFG &&
        objReq.sub == dic_pkg::SUB_RANGE) |=> thresholdSel == $past(objReq.wdata[NUM_IN-1:0]))
        else $error("threshold select not updated");

    // Refused writes and the one-cycle fault pulse
    AST_RO_WRITE_REFUSED: assert property ((objReq.valid && objReq.write && objReq.index == dic_pkg::IDX_CFG &&
        objReq.sub == dic_pkg::SUB_RAW) |=> objRsp.err)
        else $error("write to raw word not refused");
    AST_FAULT_ONE_CYCLE: assert property (interlockFault |=> !interlockFault)
        else $error("fault pulse longer than one cycle");

    // Routing table load and source decode
    AST_ROUTE_DEFAULTS: assert property ($rose(st.routeEn) |-> st.routeTab == $past(defTab))
        else $error("routing table not loaded with defaults");
    AST_ROUTE_NORMAL_IGNORED: assert property ((st.routeEn && st.routeTab[16] == 8'h81) |=>
        statusWord[dic_pkg::LEVEL_BASE] == !$past(physPad[0]))
        else $error("normal-mode words acted while routing");
    AST_ROUTE_HALL_INV: assert property ((st.routeEn && st.routeTab[31] == 8'hc1) |=>
        statusWord[31] == !$past(hallS[0]))
        else $error("inverted hall source wrong");
    AST_ROUTE_ENC: assert property ((st.routeEn && st.routeTab[31] == 8'h44) |=>
        statusWord[31] == $past(encS[0]))
        else $error("encoder source wrong");
    AST_ROUTE_ABSENT: assert property ((st.routeEn && st.routeTab[31][6:0] > 7'(NUM_IN) &&
        st.routeTab[31][6:0] <= dic_pkg::SRC_PHYS_LAST) |=> statusWord[31] == $past(st.routeTab[31][7]))
        else $error("absent input not constant");

    COV_ROUTE_ENABLE: cover property ($rose(st.routeEn));
    COV_INTERLOCK_FAULT: cover property (interlockFault);
    COV_FORCED: cover property (!st.routeEn && st.forceEn[0] && sampleTick);
    COV_ROUTE_HALL: cover property (st.routeEn && st.routeTab[3] == 8'h41);

endmodule
`default_nettype wire

// ### core/dic_pkg.sv
// Shared constants and types for the digital input conditioning block
package dic_pkg;

    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SAMPLE_PERIOD_NS = 1000000;
    localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

    // Object addresses of the configuration port
    localparam logic [15:0] IDX_CFG = 16'h3240;
    localparam logic [15:0] IDX_MAP = 16'h3242;
    localparam logic [15:0] IDX_STATUS = 16'h60fd;
    localparam logic [7:0] SUB_COUNT = 8'h00;
    localparam logic [7:0] SUB_FN_ENABLE = 8'h01;
    localparam logic [7:0] SUB_INVERT = 8'h02;
    localparam logic [7:0] SUB_FORCE_EN = 8'h03;
    localparam logic [7:0] SUB_FORCE_VAL = 8'h04;
    localparam logic [7:0] SUB_RAW = 8'h05;
    localparam logic [7:0] SUB_RANGE = 8'h06;
    localparam logic [7:0] SUB_ROUTE_EN = 8'h08;
    localparam logic [7:0] MAP_ENTRIES = 8'h20;

    // Status word layout
    localparam int FN_NEG_LIMIT = 0;
    localparam int FN_POS_LIMIT = 1;
    localparam int FN_HOME = 2;
    localparam int FN_INTERLOCK = 3;
    localparam int LEVEL_BASE = 16;
    localparam int MAX_INPUTS = 16;

    // Routing source codes
    localparam int SRC_INV_BIT = 7;
    localparam logic [6:0] SRC_CONST = 7'h00;
    localparam logic [6:0] SRC_PHYS_FIRST = 7'h01;
    localparam logic [6:0] SRC_PHYS_LAST = 7'h10;
    localparam logic [6:0] SRC_HALL_U = 7'h41;
    localparam logic [6:0] SRC_HALL_W = 7'h43;
    localparam logic [6:0] SRC_ENC_A = 7'h44;
    localparam logic [6:0] SRC_ENC_IDX = 7'h46;

    // Reset values
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic PERMIT_RESET = 1'b1;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] index;
        logic [7:0] sub;
        logic [31:0] wdata;
    } dic_obj_req_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdata;
    } dic_obj_rsp_t;

    typedef struct packed {
        logic [31:0] fnEnable;
        logic [31:0] invert;
        logic [31:0] forceEn;
        logic [31:0] forceVal;
        logic [31:0] rangeSel;
        logic routeEn;
        logic [31:0][7:0] routeTab;
        logic [31:0] status;
        logic permit;
        logic fault;
        dic_obj_rsp_t rsp;
    } dic_state_t;

    localparam dic_state_t STATE_RESET = '{
        fnEnable: CFG_RESET, invert: CFG_RESET, forceEn: CFG_RESET,
        forceVal: CFG_RESET, rangeSel: CFG_RESET, permit: PERMIT_RESET,
        default: '0};

endpackage

// ### core/dic_sampler.sv
// Input synchroniser and millisecond sampler
`timescale 1ns/100ps
`default_nettype none
module dic_sampler #(
    parameter int WIDTH = 10,
    parameter int PERIOD = dic_pkg::SAMPLE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] sampled,
    output logic tick
);
    localparam int CW = $clog2(PERIOD + 1);

    typedef struct packed {
        logic [WIDTH-1:0] sync1;
        logic [WIDTH-1:0] sync2;
        logic [WIDTH-1:0] samp;
        logic [CW-1:0] cnt;
        logic tick;
    } dic_smp_state_t;

    dic_smp_state_t st_q;
    dic_smp_state_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.sync1 = asyncIn;
        st_d.sync2 = st_q.sync1;
        st_d.tick = 1'b0;
        if (st_q.cnt == CW'(PERIOD - 1)) begin
            // Pulses shorter than a period can fall between samples
            st_d.cnt = '0;
            st_d.samp = st_q.sync2;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sampled = st_q.samp;
    assign tick = st_q.tick;

    default clocking cbs @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    AST_SAMPLE_ONLY_ON_TICK: assert property (!$stable(st_q.samp) |-> st_q.tick)
        else $error("sample changed without a tick");
    AST_TICK_SPACING: assert property (st_q.tick |=> !st_q.tick)
        else $error("sample ticks back to back");
    COV_TICK: cover property (st_q.tick);

endmodule
`default_nettype wire

// ### testbench/dic_field_model.sv
// Switches and sensors wired to the field inputs of the conditioning block
`timescale 1ns/100ps
`default_nettype none
module dic_field_model #(
    parameter int NUM_IN = 4,
    parameter int SETTLE_NS = 3
) (
    input wire logic [NUM_IN-1:0] wantPin,
    input wire logic [2:0] wantHall,
    input wire logic [2:0] wantEnc,
    output logic [NUM_IN-1:0] pinIn,
    output logic [2:0] hallIn,
    output logic [2:0] encIn
);
    // Contacts settle a little after the command, unrelated to the clock edge
    assign #(SETTLE_NS) pinIn = wantPin;
    assign #(SETTLE_NS) hallIn = wantHall;
    assign #(SETTLE_NS) encIn = wantEnc;
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the digital input conditioning block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam int NIN = 4;
    localparam int SCYC = 10;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [NIN-1:0] wantPin = '0;
    logic [2:0] wantHall = '0;
    logic [2:0] wantEnc = '0;
    logic [NIN-1:0] pinIn;
    logic [2:0] hallIn;
    logic [2:0] encIn;
    dic_pkg::dic_obj_req_t objReq = '0;
    dic_pkg::dic_obj_rsp_t objRsp;
    logic [31:0] statusWord;
    logic [NIN-1:0] thresholdSel;
    logic motionPermit;
    logic interlockFault;
    logic [31:0] rd;
    logic er;
    logic [31:0] held;
    int mismatches = 0;
    int totalChecks = 0;
    int faultPulses = 0;
    logic [7:0] codes [22] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h10, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45,
        8'h46, 8'h80, 8'h81, 8'h82, 8'h84, 8'h85, 8'h90, 8'hc1, 8'hc3, 8'hc4, 8'hc6};

    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (interlockFault === 1'b1) faultPulses++;
    end

    dic_field_model #(.NUM_IN(NIN)) field (.wantPin(wantPin), .wantHall(wantHall), .wantEnc(wantEnc),
        .pinIn(pinIn), .hallIn(hallIn), .encIn(encIn));
    dic_input_conditioning #(.NUM_IN(NIN), .SAMPLE_CYCLES(SCYC)) dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .pinIn(pinIn), .hallIn(hallIn), .encIn(encIn), .objReq(objReq), .objRsp(objRsp),
        .statusWord(statusWord), .thresholdSel(thresholdSel), .motionPermit(motionPermit),
        .interlockFault(interlockFault));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", totalChecks, mismatches);
        if (mismatches == 0 && totalChecks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One idle negedge before each request keeps valid from being driven twice in a step
    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sb, input logic [31:0] wd);
        int n;
        @(negedge clk_sys);
        objReq <= '{valid: 1'b1, write: wr, index: idx, sub: sb, wdata: wd};
        @(posedge clk_sys);
        @(negedge clk_sys);
        objReq <= '0;
        n = 0;
        while (objRsp.ack !== 1'b1 && n < 4) begin
            @(negedge clk_sys);
            n++;
        end
        if (objRsp.ack !== 1'b1) begin
            mismatches++;
            wrap_up();
        end
        rd = objRsp.rdata;
        er = objRsp.err;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] sb, input logic [31:0] wd);
        access(1'b1, idx, sb, wd);
        check({31'h0, er}, 32'h0);
    endtask

    task automatic rdChk(input logic [15:0] idx, input logic [7:0] sb, input logic [31:0] exp);
        access(1'b0, idx, sb, 32'h0);
        check({31'h0, er}, 32'h0);
        check(rd, exp);
    endtask

    task automatic settleCfg();
        repeat (4) @(negedge clk_sys);
    endtask

    // Sync flops plus one full sample period
    task automatic settleIn();
        repeat (SCYC + 8) @(negedge clk_sys);
    endtask

    function automatic logic srcVal(input logic [7:0] c);
        logic v;
        v = 1'b0;
        if (c[6:0] >= 7'h01 && int'(c[6:0]) <= NIN) v = wantPin[int'(c[6:0]) - 1];
        else if (c[6:0] >= 7'h41 && c[6:0] <= 7'h43) v = wantHall[int'(c[6:0]) - 'h41];
        else if (c[6:0] >= 7'h44 && c[6:0] <= 7'h46) v = wantEnc[int'(c[6:0]) - 'h44];
        return v ^ c[7];
    endfunction

    initial begin
        repeat (6) @(negedge clk_sys);
        rst_b = 1'b1;
        check(statusWord, 32'h0);
        check({31'h0, motionPermit}, 32'h1);
        rdChk(dic_pkg::IDX_CFG, dic_pkg::SUB_COUNT, 32'h8);
        rdChk(dic_pkg::IDX_MAP, dic_pkg::SUB_COUNT, 32'h20);
        wantPin = 4'h5;
        wantHall = 3'h5;
        wantEnc = 3'h2;
        settleIn();
        rdChk(dic_pkg::IDX_CFG, dic_pkg::SUB_RAW, 32'h5);
        check(statusWord, 32'h0005_0000);
        wr(dic_pkg::IDX_CFG, dic_pkg::SUB_FN_ENABLE, 32'h7);
        settleCfg();
        check(statusWord, 32'h0005_0005);
        wr(dic_pkg::IDX_CFG, dic_pkg::SUB_INVERT, 32'h1);
        settleCfg();
        check(statusWord, 32'h0004_0004);
        // Bit 2 of the value word is set but not forced, so it must not act
        wr(dic_pkg::IDX_CFG, dic_pkg::SUB_FORCE_EN, 32'h2);
        wr(dic_pkg::IDX_CFG, dic_pkg::SUB_FORCE_VAL, 32'h6);
        settleCfg();
        check(statusWord, 32'h0006_0006);
        rdChk(dic_pkg::IDX_CFG, dic_pkg::SUB_RAW, 32'h5);
        wr(dic_pkg::IDX_CFG, dic_pkg::SUB_RANGE, 32'ha);
        settleCfg();
        check({28'h0, thresholdSel}, 32'ha);
        rdChk(dic_pkg::IDX_CFG, dic_pkg::SUB_RANGE, 32'ha);
        check({31'h0, motionPermit}, 32'h1);
        wr(dic_pkg::IDX_CFG, dic_pkg::SUB_FN_ENABLE, 32'hf);
        settleCfg();
        check({31'h0, motionPermit}, 32'h0);
        check(faultPulses, 32'h1);
        wantPin = 4'hd;
        settleIn();
        check(statusWord, 32'h000e_000e);
        check({31'h0, motionPermit}, 32'h1);
        held = statusWord;
        wr(dic_pkg::IDX_CFG, dic_pkg::SUB_ROUTE_EN, 32'h1);
        settleCfg();
        check(statusWord, held);
        rdChk(dic_pkg::IDX_MAP, 8'h11, 32'h81);
        rdChk(dic_pkg::IDX_MAP, 8'h12, 32'h80);
        wr(dic_pkg::IDX_CFG, dic_pkg::SUB_INVERT, 32'h0);
        wr(dic_pkg::IDX_CFG, dic_pkg::SUB_FORCE_EN, 32'h0);
        settleCfg();
        check(statusWord, held);
        wr(dic_pkg::IDX_MAP, 8'h04, 32'h00);
        settleCfg();
        check({31'h0, motionPermit}, 32'h0);
        check(faultPulses, 32'h2);
        wr(dic_pkg::IDX_MAP, 8'h04, 32'h80);
        settleCfg();
        check({31'h0, motionPermit}, 32'h1);
        foreach (codes[i]) begin
            wr(dic_pkg::IDX_MAP, 8'h20, {24'h0, codes[i]});
            settleCfg();
            check({31'h0, statusWord[31]}, {31'h0, srcVal(codes[i])});
        end
        rdChk(dic_pkg::IDX_STATUS, 8'h00, 32'h800e_000e);
        access(1'b1, dic_pkg::IDX_CFG, dic_pkg::SUB_RAW, 32'hf);
        check({31'h0, er}, 32'h1);
        access(1'b1, dic_pkg::IDX_STATUS, 8'h00, 32'h0);
        check({31'h0, er}, 32'h1);
        access(1'b0, dic_pkg::IDX_CFG, 8'h07, 32'h0);
        check({31'h0, er}, 32'h1);
        rdChk(dic_pkg::IDX_CFG, dic_pkg::SUB_RAW, 32'hd);
        wrap_up();
    end
endmodule
`default_nettype wire
